// file: hdl/tcp_map.vh
`ifndef TCP_MAP_VH
`define TCP_MAP_VH
// register indices on the 4-bit byte-wide register port
`define TCP_A_SC 4'h0
`define TCP_A_CNTH 4'h1
`define TCP_A_CNTL 4'h2
`define TCP_A_MODH 4'h3
`define TCP_A_MODL 4'h4
`define TCP_A_CH0 4'h5
`define TCP_CH_STRIDE 4'h3
// module status control fields
`define TCP_SC_TOF 7
`define TCP_SC_TOIE 6
`define TCP_SC_CENTER 5
`define TCP_SC_CLKS 4:3
`define TCP_SC_PS 2:0
// channel status control fields
`define TCP_CS_CHF 7
`define TCP_CS_CHIE 6
`define TCP_CS_MS 5:4
`define TCP_CS_ELS 3:2
// clock select codes
`define TCP_CLK_NONE 2'h0
`define TCP_CLK_BUS 2'h1
`define TCP_CLK_FIX 2'h2
`define TCP_CLK_EXT 2'h3
// channel modes
`define TCP_M_CAP 2'h0
`define TCP_M_OC 2'h1
`define TCP_M_EPWM 2'h2
`define TCP_M_CENTER 2'h3
// reset values and free-running counter top
`define TCP_RST_SC 8'h00
`define TCP_RST_CS 8'h00
`define TCP_RST_MOD 16'h0000
`define TCP_RST_CV 16'h0000
`define TCP_FREE_TOP 16'hFFFF
`endif

// file: hdl/tcp_timer.v
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "tcp_map.vh"
// Function
// - each channel works as input capture, output compare or edge PWM
// - capture fires on rising, falling or either input edge
// - compare match sets, clears or toggles the channel pin
// - PWM output polarity selectable, active part high or low
// - one module bit puts all channels in center PWM, up/down count
// - prescaler source is bus clock, fixed system clock or external pin
// - prescaler divides by a power of two from 1 to 128
// - 16-bit counter counts up, or up then down in center mode
// - 16-bit modulus limits counter range and period
// - one interrupt request per channel plus terminal count request
// - any counter byte write zeroes counter and prescaler
// - in debug mode counter reads return the frozen live value
// - debug write to status control or counter clears counter read latch
// - in debug mode channel value reads return the real register
// - debug write to channel status control clears its read latch
// - compare value loads from buffer at next counter step after byte two
// - PWM values load after both bytes when counter steps mod-1 to mod
// - debug write to status control resets modulus write pairing
module tcp_timer (
    input wire clock,
    input wire rstn,
    input wire [3:0] addr,
    input wire [7:0] wrData,
    input wire wrStb,
    input wire rdStb,
    output reg [7:0] rdData,
    input wire debugMode,
    input wire fixedSysClock,
    input wire extTimerClock,
    input wire [1:0] chanIn,
    output wire [1:0] chanOut,
    output wire [1:0] chanOe,
    output wire [1:0] chanIrq,
    output wire tofIrq
);

    // mode of a channel from the center bit and its mode field
    function [1:0] chMode;
        input ctr;
        input [1:0] ms;
        begin
            if (ctr)
                chMode = `TCP_M_CENTER;
            else if (ms[1])
                chMode = `TCP_M_EPWM;
            else
                chMode = {1'b0, ms[0]};
        end
    endfunction

    reg [7:0] sc_r;
    reg [15:0] cnt_r;
    reg [15:0] mod_r;
    reg [7:0] modBuf_r;
    reg modHalf_r;
    reg [6:0] psc_r;
    reg down_r;
    reg fixPrev_r;
    reg extPrev_r;
    reg tickD_r;
    reg [15:0] cntSnap_r;
    reg cntLat_r;
    reg cntHiFirst_r;
    reg srcEdge;
    wire [15:0] chOr;
    wire [15:0] chRd;

    // source edge select; external pin is assumed slow enough to sample
    always @* begin
        case (sc_r[`TCP_SC_CLKS])
            `TCP_CLK_BUS: srcEdge = 1'b1;
            `TCP_CLK_FIX: srcEdge = fixedSysClock & ~fixPrev_r;
            `TCP_CLK_EXT: srcEdge = extTimerClock & ~extPrev_r;
            default: srcEdge = 1'b0;
        endcase
    end

    wire [6:0] psMask = ~(7'h7F << sc_r[`TCP_SC_PS]);
    wire pscDone = (psc_r & psMask) == psMask;
    wire stepEn = srcEdge & ~debugMode;
    wire tick = stepEn & pscDone;
    wire centerPwm = sc_r[`TCP_SC_CENTER];
    wire [15:0] top = (mod_r == 16'h0000) ? `TCP_FREE_TOP : mod_r;
    wire [15:0] topM1 = top - 16'h0001;
    wire wrSc = wrStb & (addr == `TCP_A_SC);
    wire cntSel = (addr == `TCP_A_CNTH) | (addr == `TCP_A_CNTL);
    wire cntWr = wrStb & cntSel;
    wire cntRd = rdStb & cntSel;
    wire isHi = addr == `TCP_A_CNTH;
    wire atTop = cnt_r == top;
    wire tofEvt = tick & atTop;
    wire clkOff = sc_r[`TCP_SC_CLKS] == `TCP_CLK_NONE;
    wire pwmLoad = tick & (cnt_r == topM1) & ~down_r; // only the step up into top

    // prescaler and main counter
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 16'h0000;
            psc_r <= 7'h00;
            down_r <= 1'b0;
            fixPrev_r <= 1'b0;
            extPrev_r <= 1'b0;
            tickD_r <= 1'b0;
        end else begin
            fixPrev_r <= fixedSysClock;
            extPrev_r <= extTimerClock;
            tickD_r <= tick & ~cntWr;
            if (cntWr) begin
                cnt_r <= 16'h0000;
                psc_r <= 7'h00;
                down_r <= 1'b0;
            end else if (stepEn) begin
                psc_r <= pscDone ? 7'h00 : psc_r + 7'h01;
                if (tick) begin
                    if (centerPwm) begin
                        // up to top, then back down to zero
                        if (down_r) begin
                            cnt_r <= cnt_r - 16'h0001;
                            if (cnt_r == 16'h0001)
                                down_r <= 1'b0;
                        end else if (atTop) begin
                            cnt_r <= cnt_r - 16'h0001;
                            down_r <= 1'b1;
                        end else begin
                            cnt_r <= cnt_r + 16'h0001;
                        end
                    end else begin
                        cnt_r <= atTop ? 16'h0000 : cnt_r + 16'h0001;
                        down_r <= 1'b0;
                    end
                end
            end
        end
    end

    // status control; overflow flag set beats a software clear
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sc_r <= `TCP_RST_SC;
        end else begin
            if (wrSc)
                sc_r[6:0] <= wrData[6:0];
            sc_r[`TCP_SC_TOF] <= tofEvt | (sc_r[`TCP_SC_TOF] & ~(wrSc & ~wrData[7]));
        end
    end

    // modulus pairs high then low byte
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mod_r <= `TCP_RST_MOD;
            modBuf_r <= 8'h00;
            modHalf_r <= 1'b0;
        end else if (debugMode & wrSc) begin
            modHalf_r <= 1'b0;
        end else if (wrStb & (addr == `TCP_A_MODH)) begin
            modBuf_r <= wrData;
            modHalf_r <= 1'b1;
        end else if (wrStb & (addr == `TCP_A_MODL) & modHalf_r) begin
            mod_r <= {modBuf_r, wrData};
            modHalf_r <= 1'b0;
        end
    end

    // counter read latch; first byte read snapshots the whole word
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cntSnap_r <= 16'h0000;
            cntLat_r <= 1'b0;
            cntHiFirst_r <= 1'b0;
        end else if (cntWr | (debugMode & wrSc)) begin
            cntLat_r <= 1'b0;
        end else if (cntRd & ~debugMode) begin
            if (!cntLat_r) begin
                cntSnap_r <= cnt_r;
                cntLat_r <= 1'b1;
                cntHiFirst_r <= isHi;
            end else if (isHi != cntHiFirst_r) begin
                cntLat_r <= 1'b0;
            end
        end
    end

    // debug reads bypass the latch so the frozen count is seen
    wire [15:0] cntView = (cntLat_r & ~debugMode) ? cntSnap_r : cnt_r;

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : gCh
            localparam integer ASCI = `TCP_A_CH0 + i * `TCP_CH_STRIDE;
            localparam [3:0] ASC = ASCI[3:0];
            localparam [3:0] AVH = ASC + 4'h1;
            localparam [3:0] AVL = ASC + 4'h2;
            reg [7:0] cs_r;
            reg [15:0] cv_r;
            reg [7:0] vBuf_r;
            reg vHalf_r;
            reg pend_r;
            reg [15:0] pendVal_r;
            reg [15:0] snap_r;
            reg lat_r;
            reg hiFirst_r;
            reg inPrev_r;
            reg out_r;
            wire [1:0] mode = chMode(centerPwm, cs_r[`TCP_CS_MS]);
            wire [1:0] els = cs_r[`TCP_CS_ELS];
            wire csWr = wrStb & (addr == ASC);
            wire vSel = (addr == AVH) | (addr == AVL);
            wire rise = chanIn[i] & ~inPrev_r;
            wire fall = ~chanIn[i] & inPrev_r;
            wire capEvt = (mode == `TCP_M_CAP) & ((els[0] & rise) | (els[1] & fall));
            wire match = tickD_r & (cnt_r == cv_r);
            wire ocEvt = (mode == `TCP_M_OC) & match;
            wire chEvt = capEvt | ocEvt | ((mode[1]) & match);
            wire active = cnt_r < cv_r;
            // load moment depends on mode; no clock means load at once
            wire doLoad = pend_r & (clkOff | ((mode == `TCP_M_OC) & tick) | (mode[1] & pwmLoad));
            wire [15:0] vView = (lat_r & ~debugMode) ? snap_r : cv_r;

            // channel control with flag set beating clear
            always @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    cs_r <= `TCP_RST_CS;
                    inPrev_r <= 1'b0;
                end else begin
                    inPrev_r <= chanIn[i];
                    if (csWr)
                        cs_r[6:0] <= wrData[6:0];
                    cs_r[`TCP_CS_CHF] <= chEvt | (cs_r[`TCP_CS_CHF] & ~(csWr & ~wrData[7]));
                end
            end

            // value buffer; writes in capture mode are ignored
            always @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    cv_r <= `TCP_RST_CV;
                    vBuf_r <= 8'h00;
                    vHalf_r <= 1'b0;
                    pend_r <= 1'b0;
                    pendVal_r <= `TCP_RST_CV;
                end else begin
                    if (capEvt)
                        cv_r <= cnt_r;
                    else if (doLoad)
                        cv_r <= pendVal_r;
                    if (doLoad)
                        pend_r <= 1'b0;
                    if (wrStb & (addr == AVH) & (mode != `TCP_M_CAP)) begin
                        vBuf_r <= wrData;
                        vHalf_r <= 1'b1;
                    end else if (wrStb & (addr == AVL) & vHalf_r & (mode != `TCP_M_CAP)) begin
                        pendVal_r <= {vBuf_r, wrData};
                        pend_r <= 1'b1;
                        vHalf_r <= 1'b0;
                    end
                end
            end

            // value read latch
            always @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    snap_r <= 16'h0000;
                    lat_r <= 1'b0;
                    hiFirst_r <= 1'b0;
                end else if (debugMode & csWr) begin
                    lat_r <= 1'b0;
                end else if (rdStb & vSel & ~debugMode) begin
                    if (!lat_r) begin
                        snap_r <= cv_r;
                        lat_r <= 1'b1;
                        hiFirst_r <= addr == AVH;
                    end else if ((addr == AVH) != hiFirst_r) begin
                        lat_r <= 1'b0;
                    end
                end
            end

            // pin drive; pwm output is re-evaluated every cycle
            always @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    out_r <= 1'b0;
                end else if (mode[1]) begin
                    out_r <= els[0] ? ~active : active;
                end else if (ocEvt) begin
                    case (els)
                        2'h1: out_r <= ~out_r;
                        2'h2: out_r <= 1'b0;
                        2'h3: out_r <= 1'b1;
                        default: out_r <= out_r;
                    endcase
                end
            end

            assign chanOut[i] = out_r;
            assign chanOe[i] = (mode != `TCP_M_CAP) & (els != 2'h0);
            assign chanIrq[i] = cs_r[`TCP_CS_CHF] & cs_r[`TCP_CS_CHIE];
            assign chRd[i*8 +: 8] = (addr == ASC) ? cs_r :
                                    (addr == AVH) ? vView[15:8] :
                                    (addr == AVL) ? vView[7:0] : 8'h00;
        end
    endgenerate

    assign chOr = {8'h00, chRd[7:0] | chRd[15:8]};
    assign tofIrq = sc_r[`TCP_SC_TOF] & sc_r[`TCP_SC_TOIE];

    // read data valid only in the cycle after the strobe
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdData <= 8'h00;
        end else if (rdStb) begin
            case (addr)
                `TCP_A_SC: rdData <= sc_r;
                `TCP_A_CNTH: rdData <= cntView[15:8];
                `TCP_A_CNTL: rdData <= cntView[7:0];
                `TCP_A_MODH: rdData <= mod_r[15:8];
                `TCP_A_MODL: rdData <= mod_r[7:0];
                default: rdData <= chOr[7:0];
            endcase
        end else begin
            rdData <= 8'h00;
        end
    end

endmodule // tcp_timer

// file: verif/tcp_pins.sv
`timescale 1ns/1ps
module tcp_pins (
    input wire clock,
    input wire rstn,
    input wire extRun,
    input wire [1:0] pinSet,
    output reg [1:0] chanIn,
    output reg fixedSysClock,
    output reg extTimerClock
);
    reg [1:0] div_r;
    // pin sources; ext clock stands still unless a run is asked for
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_r <= 2'h0;
            chanIn <= 2'h0;
            fixedSysClock <= 1'b0;
            extTimerClock <= 1'b0;
        end else begin
            div_r <= div_r + 2'h1;
            chanIn <= pinSet;
            fixedSysClock <= ~fixedSysClock;
            extTimerClock <= extRun & div_r[1];
        end
    end
endmodule // tcp_pins

// file: verif/tcp_timer_sva.sv
`timescale 1ns/1ps
`include "tcp_map.vh"
module tcp_timer_sva (
    input wire clock,
    input wire rstn,
    input wire [3:0] addr,
    input wire [7:0] wrData,
    input wire wrStb,
    input wire rdStb,
    input wire [7:0] rdData,
    input wire debugMode,
    input wire fixedSysClock,
    input wire extTimerClock,
    input wire [1:0] chanIn,
    input wire [1:0] chanOut,
    input wire [1:0] chanOe,
    input wire [1:0] chanIrq,
    input wire tofIrq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // two frozen counter reads with one idle cycle between
    sequence dbgRd_s;
        debugMode && !wrStb ##1 debugMode && rdStb && addr == `TCP_A_CNTL && !wrStb
            ##1 debugMode && !wrStb ##1 debugMode && rdStb && addr == `TCP_A_CNTL;
    endsequence
    rd_idle_a: assert property (!rdStb |=> rdData == 8'h00)
        else $error("read data outside its slot");
    unmapped_rd_a: assert property (rdStb && addr >= 4'hB |=> rdData == 8'h00)
        else $error("unmapped read not zero");
    oe_cfg_a: assert property (!$stable(chanOe) |-> $past(wrStb))
        else $error("output enable moved without a write");
    chirq_clr_a: assert property ($fell(chanIrq[0]) || $fell(chanIrq[1]) |-> $past(wrStb))
        else $error("channel request dropped without a write");
    tof_clr_a: assert property ($fell(tofIrq) |-> $past(wrStb))
        else $error("terminal request dropped without a write");
    dbg_freeze_a: assert property ($rose(tofIrq) && !$past(wrStb) |-> !$past(debugMode))
        else $error("counter wrapped while frozen");
    dbg_read_a: assert property (dbgRd_s |=> rdData == $past(rdData, 2))
        else $error("frozen counter read changed");
    dbg_clear_a: assert property (debugMode && wrStb && addr == `TCP_A_CNTH ##2
        debugMode && rdStb && addr == `TCP_A_CNTL |=> rdData == 8'h00)
        else $error("counter not cleared by write");
    cover property ($rose(tofIrq));
    cover property ($rose(chanIrq[0]));
    cover property (chanOe[1] && chanOut[1]);
endmodule // tcp_timer_sva

bind tcp_timer tcp_timer_sva chk (.clock(clock), .rstn(rstn), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .debugMode(debugMode),
    .fixedSysClock(fixedSysClock), .extTimerClock(extTimerClock), .chanIn(chanIn),
    .chanOut(chanOut), .chanOe(chanOe), .chanIrq(chanIrq), .tofIrq(tofIrq));

// file: verif/tcp_timer_tb.sv
`timescale 1ns/1ps
`include "tcp_map.vh"
module tcp_timer_tb;
    reg clock = 1'b0;
    reg rstn = 1'b0;
    reg [3:0] addr = 4'h0;
    reg [7:0] wrData = 8'h00;
    reg wrStb = 1'b0;
    reg rdStb = 1'b0;
    reg debugMode = 1'b0;
    reg extRun = 1'b0;
    reg [1:0] pinSet = 2'h0;
    reg [7:0] sc, d, e;
    wire [7:0] rdData;
    wire fixedSysClock, extTimerClock, tofIrq;
    wire [1:0] chanIn, chanOut, chanOe, chanIrq;
    integer failures = 0;
    integer checked = 0;
    integer cyc = 0;
    integer i, p, n;
    tcp_timer DUT (.clock(clock), .rstn(rstn), .addr(addr), .wrData(wrData),
        .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .debugMode(debugMode),
        .fixedSysClock(fixedSysClock), .extTimerClock(extTimerClock), .chanIn(chanIn),
        .chanOut(chanOut), .chanOe(chanOe), .chanIrq(chanIrq), .tofIrq(tofIrq));
    tcp_pins pins (.clock(clock), .rstn(rstn), .extRun(extRun), .pinSet(pinSet),
        .chanIn(chanIn), .fixedSysClock(fixedSysClock), .extTimerClock(extTimerClock));
    initial begin
        forever #2.5 clock = ~clock;
    end
    // hang guard, far above the whole sequence
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            end_sim;
        end
    end
    task step;
        begin
            @(posedge clock);
            #1;
        end
    endtask
    // strobes drop one cycle before the next request, never reassigned in one step
    task wr(input [3:0] a, input [7:0] v);
        begin
            step;
            addr <= a;
            wrData <= v;
            wrStb <= 1'b1;
            step;
            wrStb <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, output [7:0] v);
        begin
            step;
            addr <= a;
            rdStb <= 1'b1;
            step;
            v = rdData;
            rdStb <= 1'b0;
        end
    endtask
    task chk(input [15:0] seen, input [15:0] want);
        begin
            checked = checked + 1;
            if (seen !== want) begin
                failures = failures + 1;
                $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
            end
        end
    endtask
    task waitTof;
        begin
            n = 0;
            while (tofIrq !== 1'b1 && n < 3000) begin
                step;
                n = n + 1;
            end
        end
    endtask
    // rise to rise of the terminal request, flag cleared in between
    task period;
        begin
            wr(`TCP_A_SC, sc);
            waitTof;
            p = cyc;
            wr(`TCP_A_SC, sc);
            waitTof;
            p = cyc - p;
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d failures %0d", checked, failures);
            if (failures == 0 && checked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        for (i = 11; i < 16; i = i + 1) begin
            rd(i[3:0], d);
            chk(d, 8'h00);
        end
        wr(`TCP_A_MODH, 8'h00);
        wr(`TCP_A_MODL, 8'h03);
        for (i = 0; i < 8; i = i + 1) begin
            sc = 8'h48 | i[7:0];
            period;
            chk(p, 4 << i);
        end
        extRun <= 1'b1;
        sc = 8'h50;
        period;
        chk(p, 8);
        sc = 8'h58;
        period;
        chk(p, 16);
        sc = 8'h68;
        period;
        chk(p, 6);
        // free run, then a repeated low byte read must hit the snapshot
        wr(`TCP_A_SC, 8'h08);
        wr(`TCP_A_MODH, 8'h00);
        wr(`TCP_A_MODL, 8'h00);
        rd(`TCP_A_CNTL, e);
        rd(`TCP_A_CNTL, d);
        chk(d, e);
        rd(`TCP_A_CNTH, d);
        debugMode <= 1'b1;
        wr(`TCP_A_CNTH, 8'hAA);
        rd(`TCP_A_CNTL, d);
        chk(d, 8'h00);
        rd(`TCP_A_CNTL, d);
        chk(d, 8'h00);
        wr(`TCP_A_MODH, 8'h12);
        wr(`TCP_A_SC, 8'h08);
        wr(`TCP_A_MODL, 8'h34);
        rd(`TCP_A_MODL, d);
        chk(d, 8'h00);
        debugMode <= 1'b0;
        // capture edge selections on channel 0
        for (i = 1; i < 4; i = i + 1) begin
            e = 8'h40 | (i[7:0] << 2);
            wr(5, e);
            pinSet <= 2'h1;
            repeat (4) step;
            chk(chanIrq[0], i[0]);
            chk(chanOe[0], 1'b0);
            wr(5, e);
            pinSet <= 2'h0;
            repeat (4) step;
            chk(chanIrq[0], i[1]);
        end
        // compare actions on channel 1: set, clear, toggle
        for (i = 3; i > 0; i = i - 1) begin
            wr(8, 8'h50 | (i[7:0] << 2));
            wr(9, 8'h00);
            wr(10, 8'h20);
            wr(`TCP_A_CNTH, 8'h00);
            repeat (60) step;
            chk(chanOut[1], i != 2);
            chk(chanIrq[1], 1'b1);
        end
        // edge PWM duty and polarity on channel 0
        // modulus goes in high byte then low; counter restart keeps it below the new top
        wr(`TCP_A_MODH, 8'h00);
        wr(`TCP_A_MODL, 8'h0F);
        wr(`TCP_A_CNTH, 8'h00);
        wr(5, 8'h28);
        wr(6, 8'h00);
        wr(7, 8'h04);
        for (i = 2; i > 0; i = i - 1) begin
            wr(5, 8'h20 | (i[7:0] << 2));
            repeat (40) step;
            p = 0;
            repeat (32) begin
                step;
                p = p + chanOut[0];
            end
            chk(p, (i == 2) ? 8 : 24);
            chk(chanOe[0], 1'b1);
        end
        // latch old value, load a new one, then debug reads and latch clear
        rd(6, d);
        chk(d, 8'h00);
        wr(6, 8'h00);
        wr(7, 8'h09);
        repeat (40) step;
        debugMode <= 1'b1;
        rd(7, d);
        chk(d, 8'h09);
        wr(5, 8'h28);
        debugMode <= 1'b0;
        rd(7, d);
        chk(d, 8'h09);
        end_sim;
    end
endmodule // tcp_timer_tb
